// file: hdl/io_param_decoder.sv
`timescale 1ns/10ps
`default_nettype none

module io_param_decoder (
  input wire logic core_clk, // 20 MHz drive clock
  input wire logic rst_n, // asynchronous reset, active low
  input wire io_param_pkg::variant_t variant, // drive variant, static
  input wire logic cmdValid, // command offered
  input wire io_param_pkg::cmd_t cmd, // decoded command fields
  output logic cmdReady, // block can take a command
  output logic cmdDone, // one-cycle pulse, command finished
  output logic paramError, // one-cycle pulse, parameter rejected
  output logic waiting, // wait command stalled on its condition
  input wire logic [7:0] bankACurrent, // primary_io_bank, bit0 encoder index
  input wire logic [7:0] bankBCurrent, // top_board_io_bank or option_io_bank, bit n-1 = n
  input wire io_param_pkg::analog_t analog, // analog samples, same clock
  output logic [3:0] outSink // output n+1 sinks current when high
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [2*io_param_pkg::BANK_W-1:0] rawCur;
  logic [2*io_param_pkg::BANK_W-1:0] sync1_r;
  logic [2*io_param_pkg::BANK_W-1:0] sync2_r;
  logic [2*io_param_pkg::BANK_W-1:0] sync3_r;
  logic [2*io_param_pkg::BANK_W-1:0] stable_r;

  assign rawCur = {bankBCurrent, bankACurrent};

  // three flops; a change counts once the second and third agree
  genvar gi;
  generate
    for (gi = 0; gi < 2 * io_param_pkg::BANK_W; gi = gi + 1) begin : g_sync
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
          sync3_r[gi] <= 1'b0;
          stable_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= rawCur[gi];
          sync2_r[gi] <= sync1_r[gi];
          sync3_r[gi] <= sync2_r[gi];
          if (sync2_r[gi] == sync3_r[gi]) begin
            stable_r[gi] <= sync3_r[gi];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // point levels and edges
  // ----------------------------------------------------------------
  logic [io_param_pkg::NUM_POINTS-1:0] ptHigh;
  logic [io_param_pkg::NUM_POINTS-1:0] ptLow;
  logic [io_param_pkg::NUM_POINTS-1:0] prevHigh_r;
  logic [io_param_pkg::NUM_POINTS-1:0] ptRise;
  logic [io_param_pkg::NUM_POINTS-1:0] ptFall;
  logic aboveCmd, aboveOne, aboveTwo, belowCmd, belowOne, belowTwo;

  // analog compare against the threshold; equal is neither
  assign aboveCmd = analog.anaCmd > analog.threshold;
  assign belowCmd = analog.anaCmd < analog.threshold;
  assign aboveOne = analog.anaOne > analog.threshold;
  assign belowOne = analog.anaOne < analog.threshold;
  assign aboveTwo = analog.anaTwo > analog.threshold;
  assign belowTwo = analog.anaTwo < analog.threshold;

  // discrete: current flowing is low, no current is high
  logic [io_param_pkg::BANK_W-1:0] senseA, senseB;
  assign senseA = stable_r[io_param_pkg::BANK_W-1:0];
  assign senseB = stable_r[2*io_param_pkg::BANK_W-1:io_param_pkg::BANK_W];
  assign ptHigh = {~senseB, aboveTwo, aboveOne, aboveCmd, ~senseA};
  assign ptLow = {senseB, belowTwo, belowOne, belowCmd, senseA};

  // previous sample for edge detection
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prevHigh_r <= '1;
    end else begin
      prevHigh_r <= ptHigh;
    end
  end

  assign ptRise = ptHigh & ~prevHigh_r;
  assign ptFall = ~ptHigh & prevHigh_r;

  // ----------------------------------------------------------------
  // parameter decode
  // ----------------------------------------------------------------
  function automatic io_param_pkg::point_t mapPoint(
    input io_param_pkg::variant_t v,
    input logic x,
    input logic [7:0] ch
  );
    io_param_pkg::point_t p;
    logic optBank;
    p.valid = 1'b0;
    p.idx = io_param_pkg::IDX_ENC;
    optBank = !x && (v == io_param_pkg::VAR_EXPANDED || v == io_param_pkg::VAR_COMPACT_OPT);
    if (optBank) begin
      // second bank accepts 1..8
      if (ch >= io_param_pkg::CH_ONE && ch <= io_param_pkg::CH_EIGHT) begin
        p.valid = 1'b1;
        p.idx = 5'(ch - io_param_pkg::CH_ZERO) + io_param_pkg::IDX_BANK_B;
      end
    end else if (v == io_param_pkg::VAR_BASE || v == io_param_pkg::VAR_EXPANDED) begin
      // prefix ignored on base, selects main bank on expanded
      if (ch >= io_param_pkg::CH_ZERO && ch <= io_param_pkg::CH_COLON) begin
        p.valid = 1'b1;
        p.idx = 5'(ch - io_param_pkg::CH_ZERO);
      end
    end else begin
      // compact primary bank
      if (ch >= io_param_pkg::CH_ZERO && ch <= io_param_pkg::CH_FOUR) begin
        p.valid = 1'b1;
        p.idx = 5'(ch - io_param_pkg::CH_ZERO);
      end else if (ch == io_param_pkg::CH_EIGHT) begin
        p.valid = 1'b1;
        p.idx = io_param_pkg::IDX_ANA_ONE;
      end
    end
    return p;
  endfunction

  function automatic logic condOk(input logic [7:0] c);
    return c == io_param_pkg::CH_LOW || c == io_param_pkg::CH_HIGH ||
           c == io_param_pkg::CH_FALL || c == io_param_pkg::CH_RISE;
  endfunction

  function automatic logic condMet(
    input logic [7:0] c,
    input logic hi,
    input logic lo,
    input logic rise,
    input logic fall
  );
    logic r;
    r = 1'b0;
    if (c == io_param_pkg::CH_LOW) begin
      r = lo;
    end else if (c == io_param_pkg::CH_HIGH) begin
      r = hi;
    end else if (c == io_param_pkg::CH_FALL) begin
      r = fall;
    end else if (c == io_param_pkg::CH_RISE) begin
      r = rise;
    end
    return r;
  endfunction

  io_param_pkg::point_t pt1, pt2;
  logic waitParamOk, outParamOk, outIsLow;
  logic [7:0] outOff;

  // the second input takes the first input's bank, prefix or not
  assign pt1 = mapPoint(variant, cmd.xPrefix, cmd.num1);
  assign pt2 = mapPoint(variant, cmd.xPrefix, cmd.num2);
  assign waitParamOk = pt1.valid && condOk(cmd.cond1) &&
                       (!cmd.dual || (pt2.valid && condOk(cmd.cond2)));

  // set-output: number 1..OUT_COUNT, level L or H only
  assign outOff = cmd.num1 - io_param_pkg::CH_ONE;
  assign outIsLow = cmd.cond1 == io_param_pkg::CH_LOW;
  assign outParamOk = (outOff < 8'(io_param_pkg::OUT_COUNT)) &&
                      (outIsLow || cmd.cond1 == io_param_pkg::CH_HIGH);

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  io_param_pkg::state_t state_r, state_nxt;
  logic [4:0] idx1_r, idx2_r;
  logic [7:0] cond1_r, cond2_r;
  logic dual_r;
  logic met1, met2, waitMet, take;
  logic cmdDone_r, paramError_r, cmdReady_r, waiting_r;
  logic [3:0] outSink_r;

  assign met1 = condMet(cond1_r, ptHigh[idx1_r], ptLow[idx1_r], ptRise[idx1_r], ptFall[idx1_r]);
  assign met2 = condMet(cond2_r, ptHigh[idx2_r], ptLow[idx2_r], ptRise[idx2_r], ptFall[idx2_r]);
  assign waitMet = met1 && (!dual_r || met2);
  assign take = cmdValid && (state_r == io_param_pkg::ST_IDLE);

  // next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      io_param_pkg::ST_IDLE: begin
        if (take && !cmd.setOutput && waitParamOk) begin
          state_nxt = io_param_pkg::ST_WAIT;
        end
      end
      io_param_pkg::ST_WAIT: begin
        if (waitMet) begin
          state_nxt = io_param_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = io_param_pkg::ST_IDLE;
      end
    endcase
  end

  // state and captured wait parameters
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= io_param_pkg::ST_IDLE;
      idx1_r <= io_param_pkg::IDX_ENC;
      idx2_r <= io_param_pkg::IDX_ENC;
      cond1_r <= io_param_pkg::CH_HIGH;
      cond2_r <= io_param_pkg::CH_HIGH;
      dual_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (take) begin
        idx1_r <= pt1.idx;
        idx2_r <= pt2.idx;
        cond1_r <= cmd.cond1;
        cond2_r <= cmd.cond2;
        dual_r <= cmd.dual;
      end
    end
  end

  // status pulses and outputs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmdDone_r <= 1'b0;
      paramError_r <= 1'b0;
      cmdReady_r <= 1'b0;
      waiting_r <= 1'b0;
      outSink_r <= io_param_pkg::OUT_RESET;
    end else begin
      cmdDone_r <= (take && cmd.setOutput && outParamOk) ||
                   (state_r == io_param_pkg::ST_WAIT && waitMet);
      paramError_r <= take && (cmd.setOutput ? !outParamOk : !waitParamOk);
      cmdReady_r <= state_nxt == io_param_pkg::ST_IDLE;
      waiting_r <= state_nxt == io_param_pkg::ST_WAIT;
      if (take && cmd.setOutput && outParamOk) begin
        outSink_r[outOff[1:0]] <= outIsLow;
      end
    end
  end

  assign cmdDone = cmdDone_r;
  assign paramError = paramError_r;
  assign cmdReady = cmdReady_r;
  assign waiting = waiting_r;
  assign outSink = outSink_r;

endmodule

`default_nettype wire

// file: hdl/io_param_pkg.sv
package io_param_pkg;

  // ----------------------------------------------------------------
  // variants, characters and point indices
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    VAR_BASE = 2'h0, // single bank, 0..7, 8 cmd, 9/: analog
    VAR_EXPANDED = 2'h1, // prefix selects main bank, else top board
    VAR_COMPACT = 2'h2, // single bank, 0..4, 8 analog
    VAR_COMPACT_OPT = 2'h3 // prefix selects primary, else option bank
  } variant_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WAIT = 2'h1
  } state_t;

  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_ONE = 8'h31;
  localparam logic [7:0] CH_FOUR = 8'h34;
  localparam logic [7:0] CH_EIGHT = 8'h38;
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_LOW = 8'h4C;
  localparam logic [7:0] CH_HIGH = 8'h48;
  localparam logic [7:0] CH_FALL = 8'h46;
  localparam logic [7:0] CH_RISE = 8'h52;

  localparam int NUM_POINTS = 19; // 0 index,1-7 disc,8 cmd,9-10 analog,11-18 second bank
  localparam logic [4:0] IDX_ENC = 5'h00;
  localparam logic [4:0] IDX_ANA_ONE = 5'h09;
  localparam logic [4:0] IDX_BANK_B = 5'h0A; // second bank point n sits at n + this
  localparam logic [4:0] IDX_ANA_CMD = 5'h08;
  localparam logic [4:0] IDX_ANA_TWO = 5'h0A;
  localparam int BANK_W = 8;
  localparam int ANA_W = 12;
  localparam int OUT_COUNT = 4;
  localparam logic [OUT_COUNT-1:0] OUT_RESET = 4'h0; // no current, outputs open

  // one decoded command as it arrives from the command parser
  typedef struct packed {
    logic setOutput; // 1 set-output, 0 wait_on_input_cmd
    logic dual; // second input present
    logic xPrefix; // leading X on the first input
    logic [7:0] num1;
    logic [7:0] cond1;
    logic [7:0] num2;
    logic [7:0] cond2;
  } cmd_t;

  // analog samples and the analog_threshold_setting
  typedef struct packed {
    logic [ANA_W-1:0] anaCmd;
    logic [ANA_W-1:0] anaOne; // analog_channel_one, single_analog_channel on compact
    logic [ANA_W-1:0] anaTwo; // analog_channel_two
    logic [ANA_W-1:0] threshold;
  } analog_t;

  typedef struct packed {
    logic valid;
    logic [4:0] idx;
  } point_t;

endpackage

// file: tb/io_param_decoder_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// decoder port checks
// ------------------------------
module io_param_decoder_asserts (
  input wire logic core_clk, // clock
  input wire logic rst_n, // reset, active low
  input wire io_param_pkg::variant_t variant, // variant
  input wire logic cmdValid, // offer
  input wire io_param_pkg::cmd_t cmd, // command
  input wire logic cmdReady, // idle
  input wire logic cmdDone, // done pulse
  input wire logic paramError, // reject pulse
  input wire logic waiting, // stalled
  input wire logic [3:0] outSink // outputs
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // a command is taken
  sequence take_s;
    cmdValid && cmdReady;
  endsequence
  // output one set low or high
  sequence set_one_s(logic [7:0] c);
    take_s ##0 (cmd.setOutput && cmd.num1 == io_param_pkg::CH_ONE && cmd.cond1 == c);
  endsequence
  AST_SET_SINK: assert property (set_one_s(io_param_pkg::CH_LOW) |=>
    cmdDone && outSink[0]) else $error("set low not sinking");
  AST_SET_OPEN: assert property (set_one_s(io_param_pkg::CH_HIGH) |=>
    cmdDone && !outSink[0]) else $error("set high still sinking");
  AST_OUT_HOLD: assert property (!cmdDone |-> $stable(outSink))
    else $error("outputs moved without a command");
  AST_BAD_COND: assert property (take_s ##0 (cmd.cond1 == 8'h5A) |=>
    paramError && !cmdDone) else $error("bad condition accepted");
  AST_BAD_NUM: assert property (take_s ##0 (cmd.num1 == 8'h3B) |=> paramError)
    else $error("bad number accepted");
  AST_COMPACT_NUM: assert property (take_s ##0
    (variant == io_param_pkg::VAR_COMPACT && cmd.num1 == 8'h35) |=> paramError)
    else $error("compact number five accepted");
  AST_WAIT_ENTER: assert property (take_s ##0 !cmd.setOutput |=> waiting != paramError)
    else $error("wait neither stalled nor rejected");
  AST_WAIT_STALL: assert property (waiting |-> !cmdReady && !paramError)
    else $error("ready while stalled");
  AST_WAIT_END: assert property ($fell(waiting) |-> cmdDone && cmdReady)
    else $error("stall ended without done");
  AST_ONE_ANSWER: assert property (!(cmdDone && paramError))
    else $error("done and reject together");
endmodule
`default_nettype wire

// file: tb/io_param_decoder_condition_eval_test.sv
`timescale 1ns/10ps
`default_nettype none
module io_param_decoder_condition_eval_test;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  io_param_pkg::variant_t variant = io_param_pkg::VAR_BASE;
  logic cmdValid = 1'b0;
  io_param_pkg::cmd_t cmd = '0;
  logic [7:0] aFlow = 8'h00;
  logic [7:0] bFlow = 8'h00;
  logic [11:0] ana = 12'h064;
  logic [11:0] thr = 12'h0C8;
  logic cmdReady, cmdDone, paramError, waiting;
  logic [7:0] bankACurrent, bankBCurrent;
  logic [3:0] outSink;
  io_param_pkg::analog_t analog;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  // ------------------------------
  // design and sensors
  // ------------------------------
  io_param_decoder u_io_param_decoder (.core_clk, .rst_n, .variant, .cmdValid, .cmd,
    .cmdReady, .cmdDone, .paramError, .waiting, .bankACurrent, .bankBCurrent, .analog,
    .outSink);
  io_sensor_model u_io_sensor_model (.core_clk, .aFlow, .bFlow, .ana, .thr,
    .bankACurrent, .bankBCurrent, .analog);
  // clock and hang limit
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_total++;
      complete_run();
    end
  end
  // ------------------------------
  // helpers
  // ------------------------------
  function automatic io_param_pkg::cmd_t mk(logic [2:0] f, logic [7:0] n1, logic [7:0] c1,
    logic [7:0] n2 = 8'h00, logic [7:0] c2 = 8'h00);
    return io_param_pkg::cmd_t'({f, n1, c1, n2, c2});
  endfunction
  task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  // offer one command on a fresh cycle, return just after the edge that takes it
  task automatic send(input io_param_pkg::cmd_t c);
    @(posedge core_clk);
    #5 cmd = c;
    cmdValid = 1'b1;
    @(posedge core_clk);
    #5 cmdValid = 1'b0;
  endtask
  task automatic done_within(input int maxc, input string m);
    int k;
    k = 0;
    while (cmdDone !== 1'b1 && k < maxc) begin
      @(posedge core_clk);
      #5 k++;
    end
    chk({cmdDone, cmdReady, waiting}, 4'h6, m);
  endtask
  task automatic stall_check(input string m);
    repeat (6) @(posedge core_clk);
    #5 chk({waiting, cmdReady}, 4'h2, m);
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic test_set();
    for (int i = 0; i < 4; i++) begin
      send(mk(3'h4, 8'h31 + 8'(i), io_param_pkg::CH_LOW));
      chk(cmdDone, 4'h1, "set done");
      chk(outSink, 4'((2 << i) - 1), "sink on");
    end
    for (int i = 0; i < 4; i++) begin
      send(mk(3'h4, 8'h31 + 8'(i), io_param_pkg::CH_HIGH));
      chk(outSink, 4'(4'hE << i), "sink off");
    end
    $display("test_set done");
  endtask
  task automatic test_bad();
    send(mk(3'h4, io_param_pkg::CH_ONE, io_param_pkg::CH_FALL));
    chk({cmdDone, outSink[0], paramError}, 4'h1, "edge on output");
    send(mk(3'h1, 8'h3B, io_param_pkg::CH_LOW));
    chk({waiting, paramError}, 4'h1, "bad number");
    send(mk(3'h0, io_param_pkg::CH_ONE, 8'h5A));
    chk(paramError, 4'h1, "bad condition");
    $display("test_bad done");
  endtask
  task automatic test_level();
    send(mk(3'h1, io_param_pkg::CH_FOUR, io_param_pkg::CH_LOW));
    stall_check("low wait stalls");
    send(mk(3'h4, io_param_pkg::CH_ONE, io_param_pkg::CH_LOW));
    chk({cmdDone, outSink[0]}, 4'h0, "set taken while stalled");
    aFlow = 8'h10;
    done_within(12, "low met");
    send(mk(3'h0, io_param_pkg::CH_FOUR, io_param_pkg::CH_HIGH));
    stall_check("high wait stalls");
    aFlow = 8'h00;
    done_within(12, "high met");
    $display("test_level done");
  endtask
  task automatic test_edge();
    send(mk(3'h0, 8'h32, io_param_pkg::CH_FALL));
    stall_check("no fall yet");
    aFlow = 8'h04;
    done_within(12, "fall seen");
    send(mk(3'h0, 8'h32, io_param_pkg::CH_RISE));
    stall_check("steady low is no rise");
    aFlow = 8'h00;
    done_within(12, "rise seen");
    $display("test_edge done");
  endtask
  task automatic test_analog();
    send(mk(3'h0, 8'h39, io_param_pkg::CH_LOW));
    done_within(4, "below threshold");
    ana = 12'h0C8;
    send(mk(3'h0, 8'h39, io_param_pkg::CH_HIGH));
    stall_check("equal is not high");
    ana = 12'h0C9;
    done_within(6, "above threshold");
    ana = 12'h064;
    send(mk(3'h0, io_param_pkg::CH_COLON, io_param_pkg::CH_HIGH));
    done_within(4, "channel two above");
    send(mk(3'h0, io_param_pkg::CH_EIGHT, io_param_pkg::CH_HIGH));
    done_within(4, "command input above");
    $display("test_analog done");
  endtask
  task automatic test_bank();
    variant = io_param_pkg::VAR_EXPANDED;
    aFlow = 8'h08;
    send(mk(3'h0, 8'h33, io_param_pkg::CH_LOW));
    stall_check("plain number is top bank");
    bFlow = 8'h04;
    done_within(12, "top bank met");
    aFlow = 8'h06;
    send(mk(3'h3, io_param_pkg::CH_ONE, io_param_pkg::CH_LOW, 8'h32, io_param_pkg::CH_LOW));
    done_within(12, "second input on main bank");
    bFlow = 8'h80;
    send(mk(3'h0, io_param_pkg::CH_EIGHT, io_param_pkg::CH_LOW));
    done_within(12, "top bank eight");
    variant = io_param_pkg::VAR_COMPACT;
    send(mk(3'h0, 8'h35, io_param_pkg::CH_LOW));
    chk(paramError, 4'h1, "compact five");
    send(mk(3'h0, io_param_pkg::CH_EIGHT, io_param_pkg::CH_LOW));
    done_within(4, "compact analog below");
    variant = io_param_pkg::VAR_COMPACT_OPT;
    send(mk(3'h1, 8'h35, io_param_pkg::CH_LOW));
    chk(paramError, 4'h1, "primary five");
    bFlow = 8'h40;
    send(mk(3'h0, 8'h37, io_param_pkg::CH_LOW));
    done_within(12, "option seven");
    $display("test_bank done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    #5 rst_n = 1'b1;
    repeat (6) @(posedge core_clk);
    #5;
    test_set();
    test_bad();
    test_level();
    test_edge();
    test_analog();
    test_bank();
    complete_run();
  end
endmodule
bind io_param_decoder io_param_decoder_asserts u_io_param_decoder_asserts (.core_clk, .rst_n,
  .variant, .cmdValid, .cmd, .cmdReady, .cmdDone, .paramError, .waiting, .outSink);
`default_nettype wire

// file: tb/io_sensor_model.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// sensor side model
// ------------------------------
module io_sensor_model (
  input wire logic core_clk, // clock
  input wire logic [7:0] aFlow, // primary bank, 1 = current flows
  input wire logic [7:0] bFlow, // second bank, 1 = current flows
  input wire logic [11:0] ana, // analog sample
  input wire logic [11:0] thr, // threshold
  output logic [7:0] bankACurrent, // primary pins
  output logic [7:0] bankBCurrent, // second bank pins
  output io_param_pkg::analog_t analog // analog bundle
);
  // pins follow the wanted flow one clock later
  always_ff @(posedge core_clk) begin
    bankACurrent <= aFlow;
    bankBCurrent <= bFlow;
    analog <= {~ana, ana, ~ana, thr};
  end
endmodule
`default_nettype wire
